// ==== rtl/i2c_master_rx.sv ====
// Two-wire bus master: byte reception, sequences and multi-master arbitration
// Functional notes
// - Receive enable starts reception, ignored unless idle
// - Each rollover toggles clock, shifts data in
// - Eighth falling edge: load buffer, flag, hold
// - Reading the buffer clears buffer full
// - New byte while buffer full sets overflow
// - Buffer write during shifting sets write collision
// - Released one sampled low is a collision
// - Transmit collision: halt, clear full, release
// - Sequence collision: abort, release, clear enables
// - After collision, stop detection sets interrupt flag
// - Buffer write restarts transmission at first bit
// - Start and stop detection raise the flag
// - Stop: data low, release clock, time out
// - Data low after stop timeout is collision
// - Clock low before data release is collision
// - Received byte into buffer sets buffer full
//
// Chosen here: the placing of the registers and the APB register port.
`default_nettype none
module i2c_master_rx #(
	parameter int BRG_W = i2c_rx_pkg::BRG_W_DEF
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Clock line, open drain
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOeN,
	// Data line, open drain
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOeN
);
	// All state of the block
	typedef struct packed {
		i2c_rx_pkg::state_t fsm; // Sequencer state
		logic [1:0] step; // Phase inside a sequence
		logic [3:0] bitCnt; // Bits done in the current byte
		logic tx; // Current byte is a transmit
		logic [5:0] ctrl; // port_control_two
		logic [BRG_W-1:0] addr; // port_address_register
		logic [7:0] dbuf; // port_data_buffer
		logic [7:0] shift; // receive_shift_register
		logic bf, ov, write_collision_flag, ifl, bcl; // Status flags
		logic sDet, pDet; // Start and stop seen on the bus
		logic sclPrev, sdaPrev; // Last synchronised levels
		logic sclOeN, sdaOeN; // Pin enables, low drives the line low
		logic sclOut, sdaOut; // Pin values, always low
		logic pready, pslverr; // APB answer
		logic [31:0] prdata; // APB read data
	} regs_t;
	regs_t st;
	regs_t next_st;

	if (BRG_W < 1 || BRG_W > 8) begin : g_chk
		$error("BRG_W must lie between 1 and 8");
	end

	logic [1:0] pins; // Synchronised {scl, sda}
	logic sclS, sdaS; // Readable levels
	logic tick; // Half-bit rollover
	logic brgLoad; // Restart the half-bit timer
	logic coll; // Bus collision this cycle
	logic rxDone; // Eighth received bit ends now
	logic mapped; // Address decodes to a register
	logic wrAcc, rdAcc; // APB access phase completes
	logic startSeen, stopSeen; // Bus conditions on the lines
	logic [31:0] rdVal; // Read mux

	// Both pins pass two flops before anything looks at them
	pin_sync #(.WIDTH(2)) u_sync (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.din({sclIn, sdaIn}),
		.dout(pins)
	);
	assign sclS = pins[1];
	assign sdaS = pins[0];

	// Half-bit timer, reloaded from the address register
	bit_rate_counter #(.BRG_W(BRG_W)) u_brg (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.load(brgLoad),
		.reload(st.addr),
		.tick(tick)
	);

	// Bus decode and read mux
	always_comb begin
		mapped = 1'b1;
		rdVal = 32'h0;
		case (paddr)
			i2c_rx_pkg::CTRL_OFF: rdVal[5:0] = st.ctrl;
			i2c_rx_pkg::STAT_OFF: rdVal[6:0] = {st.bcl, st.ifl, st.write_collision_flag, st.ov, st.sDet,
				st.pDet, st.bf};
			i2c_rx_pkg::DATA_OFF: rdVal[7:0] = st.dbuf;
			i2c_rx_pkg::ADDR_OFF: rdVal[BRG_W-1:0] = st.addr;
			default: mapped = 1'b0;
		endcase
	end
	assign wrAcc = psel && penable && st.pready && pwrite && mapped;
	assign rdAcc = psel && penable && st.pready && !pwrite && mapped;
	// Start: data falls while clock high; stop: data rises while clock high
	assign startSeen = st.sclPrev && sclS && st.sdaPrev && !sdaS;
	assign stopSeen = st.sclPrev && sclS && !st.sdaPrev && sdaS;

	// Next state: bus, then sequencer; later sets win over earlier clears
	always_comb begin
		next_st = st;
		brgLoad = 1'b0;
		coll = 1'b0;
		rxDone = 1'b0;
		next_st.sclPrev = sclS;
		next_st.sdaPrev = sdaS;
		next_st.pready = 1'b0;
		// No wait state: answer is registered in the setup cycle
		if (psel && !penable) begin
			next_st.pready = 1'b1;
			next_st.pslverr = !mapped;
			next_st.prdata = rdVal;
		end
		if (wrAcc) begin
			case (paddr)
				i2c_rx_pkg::CTRL_OFF: begin
					next_st.ctrl[i2c_rx_pkg::ACKDT_B] = pwdata[i2c_rx_pkg::ACKDT_B];
					// Enables are taken only from idle, one at a time
					if (st.fsm == i2c_rx_pkg::ST_IDLE) begin
						brgLoad = |pwdata[4:0];
						next_st.step = 2'd0;
						next_st.bitCnt = 4'h0;
						next_st.tx = 1'b0;
						if (pwdata[i2c_rx_pkg::START_B]) begin
							// Lines already free: go straight to pulling data low
							next_st.ctrl[i2c_rx_pkg::START_B] = 1'b1;
							next_st.fsm = i2c_rx_pkg::ST_RSTART;
							next_st.step = 2'd2;
						end else if (pwdata[i2c_rx_pkg::RSTART_B]) begin
							next_st.ctrl[i2c_rx_pkg::RSTART_B] = 1'b1;
							next_st.fsm = i2c_rx_pkg::ST_RSTART;
						end else if (pwdata[i2c_rx_pkg::STOP_B]) begin
							next_st.ctrl[i2c_rx_pkg::STOP_B] = 1'b1;
							next_st.fsm = i2c_rx_pkg::ST_STOP;
						end else if (pwdata[i2c_rx_pkg::RECEIVE_ENABLE_BIT_B]) begin
							next_st.ctrl[i2c_rx_pkg::RECEIVE_ENABLE_BIT_B] = 1'b1;
							next_st.fsm = i2c_rx_pkg::ST_XFER;
						end else if (pwdata[i2c_rx_pkg::ACK_SEQUENCE_ENABLE_B]) begin
							next_st.ctrl[i2c_rx_pkg::ACK_SEQUENCE_ENABLE_B] = 1'b1;
							next_st.fsm = i2c_rx_pkg::ST_ACK;
						end
					end
				end
				i2c_rx_pkg::STAT_OFF: begin
					// Write one to clear the sticky flags
					next_st.ov = st.ov & ~pwdata[i2c_rx_pkg::OV_B];
					next_st.write_collision_flag = st.write_collision_flag & ~pwdata[i2c_rx_pkg::WRITE_COLLISION_FLAG_B];
					next_st.ifl = st.ifl & ~pwdata[i2c_rx_pkg::IFL_B];
					next_st.bcl = st.bcl & ~pwdata[i2c_rx_pkg::BCL_B];
				end
				i2c_rx_pkg::DATA_OFF: begin
					if (st.fsm != i2c_rx_pkg::ST_IDLE) begin
						next_st.write_collision_flag = 1'b1;
					end else begin
						// Always from the first bit, whatever was cut short before
						next_st.dbuf = pwdata[7:0];
						next_st.shift = pwdata[7:0];
						next_st.bf = 1'b1;
						next_st.tx = 1'b1;
						next_st.bitCnt = 4'h0;
						next_st.step = 2'd0;
						next_st.fsm = i2c_rx_pkg::ST_XFER;
						brgLoad = 1'b1;
					end
				end
				default: next_st.addr = pwdata[BRG_W-1:0];
			endcase
		end
		if (rdAcc && paddr == i2c_rx_pkg::DATA_OFF) begin
			next_st.bf = 1'b0;
		end
		// Bus monitor keeps running in every state, also after a collision
		if (startSeen) begin
			next_st.sDet = 1'b1;
			next_st.pDet = 1'b0;
			next_st.ifl = 1'b1;
		end
		if (stopSeen) begin
			next_st.pDet = 1'b1;
			next_st.sDet = 1'b0;
			next_st.ifl = 1'b1;
		end
		// Sequencer; each tick is one rollover; in ST_XFER and ST_ACK it flips the clock line
		case (st.fsm)
			i2c_rx_pkg::ST_IDLE: begin
				// Clock stays where the last sequence left it
			end
			i2c_rx_pkg::ST_RSTART: begin
				case (st.step)
					2'd0: begin
						next_st.sdaOeN = 1'b1;
						if (tick) begin
							next_st.sclOeN = 1'b1;
							next_st.step = 2'd1;
						end
					end
					2'd1: begin
						// Wait for other masters to let the clock rise
						if (sclS) begin
							brgLoad = 1'b1;
							next_st.step = 2'd2;
						end
					end
					2'd2: begin
						if (tick) begin
							// Data expected high here; low means another master
							coll = !sdaS || !sclS;
							next_st.sdaOeN = 1'b0;
							brgLoad = 1'b1;
							next_st.step = 2'd3;
						end
					end
					default: begin
						if (tick) begin
							next_st.sclOeN = 1'b0;
							next_st.ctrl[1:0] = 2'b00;
							next_st.ifl = 1'b1;
							next_st.fsm = i2c_rx_pkg::ST_IDLE;
						end
					end
				endcase
			end
			i2c_rx_pkg::ST_STOP: begin
				case (st.step)
					2'd0: begin
						next_st.sdaOeN = 1'b0;
						if (tick) begin
							if (!sdaS) begin
								next_st.sclOeN = 1'b1;
								next_st.step = 2'd1;
							end else begin
								// Low level not through the synchroniser yet: time one more half
								brgLoad = 1'b1;
							end
						end
					end
					2'd1: begin
						if (sclS) begin
							brgLoad = 1'b1;
							next_st.step = 2'd2;
						end
					end
					2'd2: begin
						// Clock pulled low again before data release
						if (!sclS) begin
							coll = 1'b1;
						end else if (tick) begin
							next_st.sdaOeN = 1'b1;
							brgLoad = 1'b1;
							next_st.step = 2'd3;
						end
					end
					default: begin
						if (tick) begin
							if (!sdaS) begin
								coll = 1'b1;
							end else begin
								next_st.ctrl[i2c_rx_pkg::STOP_B] = 1'b0;
								next_st.ifl = 1'b1;
								next_st.fsm = i2c_rx_pkg::ST_IDLE;
							end
						end
					end
				endcase
			end
			i2c_rx_pkg::ST_XFER: begin
				case (st.step)
					2'd0: begin
						next_st.sclOeN = 1'b0;
						// Receive and acknowledge slot release data; else send bit 7
						next_st.sdaOeN = !st.tx || st.bitCnt == i2c_rx_pkg::LAST_TX ||
							st.shift[7];
						if (tick) begin
							next_st.sclOeN = 1'b1;
							next_st.step = 2'd1;
						end
					end
					2'd1: begin
						if (sclS) begin
							brgLoad = 1'b1;
							next_st.step = 2'd2;
							// Sampled once the clock is really high
							next_st.shift = {st.shift[6:0], sdaS};
							coll = st.tx && st.sdaOeN && !sdaS &&
								st.bitCnt != i2c_rx_pkg::LAST_TX;
						end
					end
					default: begin
						if (tick) begin
							next_st.sclOeN = 1'b0;
							next_st.bitCnt = st.bitCnt + 4'h1;
							next_st.step = 2'd0;
							// Time the low half of the next bit; a stopped timer would hang here
							brgLoad = 1'b1;
							if (!st.tx && st.bitCnt == i2c_rx_pkg::LAST_RX) begin
								rxDone = 1'b1;
								brgLoad = 1'b0;
								next_st.ctrl[i2c_rx_pkg::RECEIVE_ENABLE_BIT_B] = 1'b0;
								next_st.ifl = 1'b1;
								next_st.fsm = i2c_rx_pkg::ST_IDLE;
								// Overrun keeps the unread byte; new one is dropped
								if (st.bf) begin
									next_st.ov = 1'b1;
								end else begin
									next_st.dbuf = st.shift;
									next_st.bf = 1'b1;
								end
							end else if (st.tx && st.bitCnt == i2c_rx_pkg::LAST_TX) begin
								brgLoad = 1'b0;
								next_st.bf = 1'b0;
								next_st.tx = 1'b0;
								next_st.ifl = 1'b1;
								next_st.fsm = i2c_rx_pkg::ST_IDLE;
							end
						end
					end
				endcase
			end
			i2c_rx_pkg::ST_ACK: begin
				case (st.step)
					2'd0: begin
						next_st.sclOeN = 1'b0;
						next_st.sdaOeN = st.ctrl[i2c_rx_pkg::ACKDT_B];
						if (tick) begin
							next_st.sclOeN = 1'b1;
							next_st.step = 2'd1;
						end
					end
					2'd1: begin
						if (sclS) begin
							brgLoad = 1'b1;
							next_st.step = 2'd2;
							coll = st.sdaOeN && !sdaS;
						end
					end
					default: begin
						if (tick) begin
							next_st.sclOeN = 1'b0;
							next_st.ctrl[i2c_rx_pkg::ACK_SEQUENCE_ENABLE_B] = 1'b0;
							next_st.ifl = 1'b1;
							next_st.fsm = i2c_rx_pkg::ST_IDLE;
						end
					end
				endcase
			end
			default: next_st.fsm = i2c_rx_pkg::ST_IDLE;
		endcase
		// Lost arbitration: free both lines, drop the sequence, flag it
		if (coll) begin
			next_st.fsm = i2c_rx_pkg::ST_IDLE;
			next_st.sclOeN = 1'b1;
			next_st.sdaOeN = 1'b1;
			next_st.ctrl[4:0] = 5'h00;
			next_st.bcl = 1'b1;
			next_st.tx = 1'b0;
			if (st.tx) begin
				next_st.bf = 1'b0;
			end
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
			st.ctrl <= i2c_rx_pkg::CTRL_RST;
			st.addr <= BRG_W'(i2c_rx_pkg::ADDR_RST);
			st.sclOeN <= 1'b1;
			st.sdaOeN <= 1'b1;
			st.sclPrev <= 1'b1;
			st.sdaPrev <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign sclOut = st.sclOut;
	assign sdaOut = st.sdaOut;
	assign sclOeN = st.sclOeN;
	assign sdaOeN = st.sdaOeN;

	// Checks on the sequencer and the flags
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	a_receive_enable_bit_ignored: assert property (
		wrAcc && paddr == i2c_rx_pkg::CTRL_OFF && st.fsm != i2c_rx_pkg::ST_IDLE |=>
		st.ctrl[4:0] == $past(st.ctrl[4:0]) || coll || $past(coll))
		else $error("control enable taken while busy");
	a_rx_done: assert property (
		rxDone |=> st.fsm == i2c_rx_pkg::ST_IDLE && !st.ctrl[i2c_rx_pkg::RECEIVE_ENABLE_BIT_B] &&
		st.bf && st.ifl && !st.sclOeN)
		else $error("end of reception not handled");
	a_bf_clear: assert property (
		rdAcc && paddr == i2c_rx_pkg::DATA_OFF && !rxDone |=> !st.bf)
		else $error("buffer read left buffer full set");
	a_ovf_set: assert property (
		rxDone && st.bf |=> st.ov && st.dbuf == $past(st.dbuf))
		else $error("overflow not flagged");
	a_write_collision_flag_keep: assert property (
		wrAcc && paddr == i2c_rx_pkg::DATA_OFF && st.fsm != i2c_rx_pkg::ST_IDLE |=>
		st.write_collision_flag && st.dbuf == $past(st.dbuf))
		else $error("write collision mishandled");
	a_coll_release: assert property (
		coll |=> st.bcl && st.sclOeN && st.sdaOeN && st.ctrl[4:0] == 5'h00 &&
		st.fsm == i2c_rx_pkg::ST_IDLE)
		else $error("collision did not release the bus");
	a_coll_bf: assert property (
		coll && st.tx |=> !st.bf)
		else $error("transmit collision kept buffer full");
	a_stop_seen: assert property (
		stopSeen |=> st.pDet && !st.sDet && st.ifl)
		else $error("stop condition not flagged");
	a_start_seen: assert property (
		startSeen |=> st.sDet && !st.pDet && st.ifl)
		else $error("start condition not flagged");
	a_tx_first: assert property (
		wrAcc && paddr == i2c_rx_pkg::DATA_OFF && st.fsm == i2c_rx_pkg::ST_IDLE |=>
		st.fsm == i2c_rx_pkg::ST_XFER && st.bitCnt == 4'h0 && st.shift == $past(pwdata[7:0]))
		else $error("transmit did not restart at first bit");
	a_scl_hold: assert property (
		rxDone ##1 (st.fsm == i2c_rx_pkg::ST_IDLE)[*3] |-> !st.sclOeN)
		else $error("clock not held low after reception");
	c_rx_byte: cover property (rxDone);
	c_collision: cover property (coll);
	c_stop_done: cover property (st.fsm == i2c_rx_pkg::ST_STOP ##[1:1000]
		st.fsm == i2c_rx_pkg::ST_IDLE && st.pDet);
endmodule
`default_nettype wire

// ==== shared/i2c_rx_pkg.sv ====
// Shared constants and types of the two-wire master receive and arbitration block
`default_nettype none
package i2c_rx_pkg;
	// APB register byte offsets
	localparam logic [7:0] CTRL_OFF = 8'h00; // port_control_two
	localparam logic [7:0] STAT_OFF = 8'h04; // port_status_register
	localparam logic [7:0] DATA_OFF = 8'h08; // port_data_buffer
	localparam logic [7:0] ADDR_OFF = 8'h0c; // port_address_register (bit rate reload)
	// port_control_two bit positions
	localparam int START_B = 0;
	localparam int RSTART_B = 1;
	localparam int STOP_B = 2;
	localparam int RECEIVE_ENABLE_BIT_B = 3; // receive_enable_bit
	localparam int ACK_SEQUENCE_ENABLE_B = 4; // ack_sequence_enable
	localparam int ACKDT_B = 5; // Acknowledge data value, 1 sends a not-acknowledge
	// port_status_register bit positions
	localparam int BF_B = 0;
	localparam int PDET_B = 1;
	localparam int SDET_B = 2;
	localparam int OV_B = 3;
	localparam int WRITE_COLLISION_FLAG_B = 4;
	localparam int IFL_B = 5;
	localparam int BCL_B = 6;
	// Widths and reset values
	localparam int CTRL_W = 6;
	localparam int STAT_W = 7;
	localparam int BRG_W_DEF = 7;
	localparam logic [6:0] ADDR_RST = 7'h04;
	localparam logic [5:0] CTRL_RST = 6'h00;
	// Bit counter end points: eight data bits, then one acknowledge slot on transmit
	localparam logic [3:0] LAST_RX = 4'h7;
	localparam logic [3:0] LAST_TX = 4'h8;
	// Sequencer states
	typedef enum logic [2:0] {ST_IDLE, ST_RSTART, ST_STOP, ST_XFER, ST_ACK} state_t;
endpackage
`default_nettype wire

// ==== rtl/pin_sync.sv ====
// Two-flop synchroniser for the bus pin inputs
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Raw and synchronised levels
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	// Idle bus level is high, so both stages reset high
	typedef struct packed {
		logic [WIDTH-1:0] meta; // First stage, read only by the second
		logic [WIDTH-1:0] sync; // Second stage
	} sync_t;
	sync_t st;
	sync_t next_st;

	if (WIDTH < 1) begin : g_chk
		$error("pin_sync WIDTH must be at least 1");
	end

	// Shift the pins through both stages
	always_comb begin
		next_st.meta = din;
		next_st.sync = st.meta;
	end

	// State register
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '1;
		end else begin
			st <= next_st;
		end
	end

	assign dout = st.sync;
endmodule
`default_nettype wire

// ==== rtl/bit_rate_counter.sv ====
// Reloadable down counter that times each half bit on the bus
`default_nettype none
module bit_rate_counter #(
	parameter int BRG_W = 7
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Control
	input wire logic load,
	input wire logic [BRG_W-1:0] reload,
	// One-cycle rollover pulse
	output logic tick
);
	typedef struct packed {
		logic [BRG_W-1:0] cnt; // Remaining cycles
		logic run; // Counting; cleared at rollover so the line is held
	} brg_t;
	brg_t st;
	brg_t next_st;

	if (BRG_W < 1) begin : g_chk
		$error("bit_rate_counter BRG_W must be at least 1");
	end

	// Rollover when a running count reaches zero
	assign tick = st.run && (st.cnt == '0);

	// Load wins over counting, so a restart is never lost
	always_comb begin
		next_st = st;
		if (load) begin
			next_st.cnt = reload;
			next_st.run = 1'b1;
		end else if (tick) begin
			next_st.run = 1'b0;
		end else if (st.run) begin
			next_st.cnt = st.cnt - 1'b1;
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule
`default_nettype wire

// ==== verif/bus_partner.sv ====
// Behavioural far-side party of the two-wire bus: byte source, sniffer and disturber
`default_nettype none
module bus_partner (
	// Resolved bus levels
	input wire logic scl,
	input wire logic sda,
	// Bench commands
	input wire logic [7:0] txByte,
	input wire logic sendEn,
	input wire logic holdSda,
	input wire logic grabScl,
	// Pulls, high while this party sinks the line
	output logic sdaPull,
	output var logic sclPull,
	// Levels sampled on clock rises, and their count
	output var logic [8:0] seen,
	output var int edges
);
	timeunit 1ns;
	timeprecision 1ps;
	int cur; // Index of the bit now on the data line
	initial begin
		sclPull = 1'b0;
		seen = '0;
		edges = 0;
		cur = 0;
	end
	// A new byte restarts the bit count
	always @(posedge sendEn) begin
		edges = 0;
		// With the clock high the line stays released until it falls: no false start
		cur = scl ? 8 : 0;
	end
	// Sniff the data line on each clock rise
	always @(posedge scl) begin
		seen = {seen[7:0], sda};
		edges = edges + 1;
	end
	// Data moves only while the clock is low, so no false start or stop appears
	always @(negedge scl) begin
		cur = edges;
	end
	// Most significant bit first; a one leaves the line to the pull-up
	assign sdaPull = holdSda || (sendEn && cur < 8 && !txByte[7 - cur]);
	// Another master pulls the clock low soon after it rises
	always @(posedge scl) begin
		if (grabScl) begin
			// Mid-cycle, so the pull never lands on a system clock edge
			#6 sclPull = 1'b1;
			#40 sclPull = 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== verif/i2c_master_rx_tb.sv ====
// Self-checking bench of the two-wire master receive and arbitration block
`default_nettype none
`define CHECK(nm, ex, gt) begin checksDone++; if ((gt) !== (ex)) begin errors++; \
	$display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end
module i2c_master_rx_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// Register offsets and field masks taken from the package
	localparam logic [7:0] CT = i2c_rx_pkg::CTRL_OFF;
	localparam logic [7:0] ST = i2c_rx_pkg::STAT_OFF;
	localparam logic [7:0] DT = i2c_rx_pkg::DATA_OFF;
	localparam logic [7:0] AD = i2c_rx_pkg::ADDR_OFF;
	localparam logic [31:0] M_START = 32'h1 << i2c_rx_pkg::START_B;
	localparam logic [31:0] M_RSTART = 32'h1 << i2c_rx_pkg::RSTART_B;
	localparam logic [31:0] M_STOP = 32'h1 << i2c_rx_pkg::STOP_B;
	localparam logic [31:0] M_RECEIVE_ENABLE_BIT = 32'h1 << i2c_rx_pkg::RECEIVE_ENABLE_BIT_B;
	localparam logic [31:0] M_ACK = 32'h1 << i2c_rx_pkg::ACK_SEQUENCE_ENABLE_B;
	localparam logic [31:0] M_ACKDT = 32'h1 << i2c_rx_pkg::ACKDT_B;
	localparam logic [31:0] M_BF = 32'h1 << i2c_rx_pkg::BF_B;
	localparam logic [31:0] M_PDET = 32'h1 << i2c_rx_pkg::PDET_B;
	localparam logic [31:0] M_SDET = 32'h1 << i2c_rx_pkg::SDET_B;
	localparam logic [31:0] M_OV = 32'h1 << i2c_rx_pkg::OV_B;
	localparam logic [31:0] M_WRITE_COLLISION_FLAG = 32'h1 << i2c_rx_pkg::WRITE_COLLISION_FLAG_B;
	localparam logic [31:0] M_IFL = 32'h1 << i2c_rx_pkg::IFL_B;
	localparam logic [31:0] M_BCL = 32'h1 << i2c_rx_pkg::BCL_B;
	localparam logic [31:0] M_W1C = M_OV | M_WRITE_COLLISION_FLAG | M_IFL | M_BCL;
	// Clock, reset and APB
	logic ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, slvErr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	// Pins; both lines have pull-ups, so a released line reads high
	logic sclOut, sclOeN, sdaOut, sdaOeN, sclPull, sdaPull;
	wire logic scl = (sclOeN | sclOut) & !sclPull;
	wire logic sda = (sdaOeN | sdaOut) & !sdaPull;
	// Far-side commands and observations
	logic [7:0] txByte;
	logic sendEn, holdSda, grabScl;
	logic [8:0] seen;
	int edges, errors, checksDone, cyc;
	i2c_master_rx DUT (.ref_clk(ref_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sclIn(scl), .sclOut(sclOut), .sclOeN(sclOeN), .sdaIn(sda),
		.sdaOut(sdaOut), .sdaOeN(sdaOeN));
	bus_partner partner (.scl(scl), .sda(sda), .txByte(txByte), .sendEn(sendEn),
		.holdSda(holdSda), .grabScl(grabScl), .sdaPull(sdaPull), .sclPull(sclPull),
		.seen(seen), .edges(edges));
	// Free-running system clock
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// Hang guard, far above the roughly eight hundred cycles the run needs
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 60000) begin
			`CHECK("timeout", 1'b0, 1'b1)
			results();
		end
	end
	// Verdict and end of run
	task automatic results();
		if (errors == 0 && checksDone > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// One APB transfer; request held until pready is seen high at an edge
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge ref_clk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge ref_clk);
		penable <= 1'b1;
		// No count of wait states is assumed; the hang guard ends a dead slave
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		q = prdata;
		slvErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(a, 1'b1, d, q);
	endtask
	// Poll until masked bits match; the hang guard stops a flag that never comes
	task automatic waitFor(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
		logic [31:0] q;
		do begin
			apb(a, 1'b0, '0, q);
		end while ((q & m) !== v);
	endtask
	// Read a register and compare its masked bits
	task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		apb(a, 1'b0, '0, q);
		`CHECK($sformatf("reg %h", a), e, q & m)
	endtask
	// Receive one byte supplied by the far side
	task automatic rxByte(input logic [7:0] b);
		txByte <= b;
		sendEn <= 1'b1;
		wr(CT, M_RECEIVE_ENABLE_BIT);
		waitFor(CT, M_RECEIVE_ENABLE_BIT, '0);
		sendEn <= 1'b0;
	endtask
	task automatic tReset();
		logic [31:0] q;
		`CHECK("released", 2'b11, {sclOeN, sdaOeN})
		chk(CT, '1, 32'(i2c_rx_pkg::CTRL_RST));
		chk(ST, '1, '0);
		chk(AD, '1, 32'(i2c_rx_pkg::ADDR_RST));
		apb(8'h10, 1'b0, '0, q);
		`CHECK("pslverr", 1'b1, slvErr)
		wr(AD, 32'h2);
	endtask
	// Own start and stop are seen on the bus and flagged
	task automatic tStartStop();
		wr(CT, M_START);
		waitFor(CT, M_START, '0);
		chk(ST, M_SDET | M_IFL, M_SDET | M_IFL);
		wr(ST, M_W1C);
		wr(CT, M_STOP);
		waitFor(CT, M_STOP, '0);
		chk(ST, M_PDET | M_IFL | M_BCL, M_PDET | M_IFL);
		`CHECK("lines", 2'b11, {scl, sda})
		wr(ST, M_W1C);
	endtask
	// Plain byte reception, then buffer read and acknowledge
	task automatic tRx();
		rxByte(8'ha5);
		chk(ST, M_BF | M_IFL, M_BF | M_IFL);
		`CHECK("sclOeN", 1'b0, sclOeN)
		`CHECK("edges", 8, edges)
		chk(DT, 32'hff, 32'ha5);
		chk(ST, M_BF, '0);
		wr(CT, M_ACK);
		waitFor(CT, M_ACK, '0);
		chk(ST, M_BCL, '0);
		wr(ST, M_W1C);
	endtask
	// Not-acknowledge overdriven low, then a stop made by the far side
	task automatic tAckCol();
		rxByte(8'h0f);
		chk(DT, 32'hff, 32'h0f);
		holdSda <= 1'b1;
		wr(CT, M_ACK | M_ACKDT);
		waitFor(CT, M_ACK, '0);
		chk(ST, M_BCL, M_BCL);
		`CHECK("released", 2'b11, {sclOeN, sdaOeN})
		wr(ST, M_W1C);
		holdSda <= 1'b0;
		repeat (8) @(posedge ref_clk);
		chk(ST, M_IFL | M_PDET, M_IFL | M_PDET);
		wr(ST, M_W1C);
	endtask
	// Second byte while the first is unread
	task automatic tOvf();
		rxByte(8'h3c);
		rxByte(8'hc3);
		chk(ST, M_OV | M_BF, M_OV | M_BF);
		chk(DT, 32'hff, 32'h3c);
		wr(ST, M_W1C);
	endtask
	// Buffer and control writes while a byte is shifting in
	task automatic tWcol();
		txByte <= 8'h5a;
		sendEn <= 1'b1;
		wr(CT, M_RECEIVE_ENABLE_BIT);
		wr(DT, 32'hff);
		wr(CT, M_STOP | M_RECEIVE_ENABLE_BIT);
		waitFor(CT, M_RECEIVE_ENABLE_BIT, '0);
		sendEn <= 1'b0;
		chk(ST, M_WRITE_COLLISION_FLAG | M_BF, M_WRITE_COLLISION_FLAG | M_BF);
		chk(CT, M_STOP | M_RECEIVE_ENABLE_BIT, '0);
		chk(DT, 32'hff, 32'h5a);
		wr(ST, M_W1C);
	endtask
	// Lost arbitration on the second data bit, then a fresh byte
	task automatic tTxCol();
		holdSda <= 1'b1;
		wr(DT, 32'h7f);
		waitFor(ST, M_BCL, M_BCL);
		chk(ST, M_BF, '0);
		`CHECK("released", 2'b11, {sclOeN, sdaOeN})
		holdSda <= 1'b0;
		wr(ST, M_W1C);
		wr(CT, M_START);
		waitFor(CT, M_START, '0);
		wr(ST, M_W1C);
		txByte <= 8'hff;
		sendEn <= 1'b1;
		wr(DT, 32'hc3);
		while (edges < 9) begin
			@(posedge ref_clk);
		end
		`CHECK("sent", 8'hc3, seen[8:1])
		waitFor(ST, M_IFL, M_IFL);
		chk(ST, M_WRITE_COLLISION_FLAG, '0);
		sendEn <= 1'b0;
		// Repeated start from a held-low clock, then the closing stop
		wr(ST, M_W1C);
		wr(CT, M_RSTART);
		waitFor(CT, M_RSTART, '0);
		chk(ST, M_IFL | M_BCL, M_IFL);
		wr(CT, M_STOP);
		waitFor(CT, M_STOP, '0);
		wr(ST, M_W1C);
	endtask
	// Stop disturbed by a held data line, or by a clock pulled low early
	task automatic tStopCol(input logic grab);
		wr(CT, M_START);
		waitFor(CT, M_START, '0);
		if (grab) begin
			wr(AD, 32'h4);
			grabScl <= 1'b1;
		end else begin
			holdSda <= 1'b1;
		end
		wr(CT, M_STOP);
		waitFor(CT, M_STOP, '0);
		chk(ST, M_BCL, M_BCL);
		`CHECK("released", 2'b11, {sclOeN, sdaOeN})
		grabScl <= 1'b0;
		holdSda <= 1'b0;
		wr(ST, M_W1C);
		wr(AD, 32'h2);
	endtask
	// Main sequence
	initial begin
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		txByte = 8'hff;
		sendEn = 1'b0;
		holdSda = 1'b0;
		grabScl = 1'b0;
		errors = 0;
		checksDone = 0;
		cyc = 0;
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'b1;
		tReset();
		tStartStop();
		tRx();
		tAckCol();
		tOvf();
		tWcol();
		tTxCol();
		tStopCol(1'b0);
		tStopCol(1'b1);
		results();
	end
endmodule
`undef CHECK
`default_nettype wire
